// >>> bench/cci_inserter_bench.sv
// self-checking bench for the caption line inserter
`timescale 1ns/1ps
module cci_inserter_bench;
  import cci_pkg::*;
  localparam int BIT_N = 16 * int'(CCI_SEG_CYC);
  logic mclk = 1'b0;
  logic reset_n = 1'b0;
  logic line_start = 1'b0;
  logic [9:0] line_num = 10'h000;
  logic field_odd = 1'b0;
  logic active_start = 1'b0;
  logic pix_valid = 1'b0;
  logic [9:0] pix_level = 10'h000;
  logic pix_ready;
  logic wr_en = 1'b0;
  logic [4:0] wr_addr = 5'h00;
  logic [7:0] wr_data = 8'h00;
  logic vid_valid;
  cci_smp_t vid_sample;
  logic vid_ready;
  logic [15:0] caption_byte_pair;
  logic [15:0] extended_caption_byte_pair;
  logic cc_busy;
  logic [1:0] sink_mode = 2'h0;
  logic busy_seen = 1'b0;
  int n_mismatch = 0;
  int checked = 0;
  int n_acc = 0;
  int base = 0;
  cci_smp_t s;

  always #20 mclk = ~mclk;
  always @(posedge mclk) begin
    if (pix_valid && pix_ready) begin
      n_acc <= n_acc + 1;
    end
    if (cc_busy) begin
      busy_seen <= 1'b1;
    end
  end

  cci_inserter u_cci_inserter (.mclk(mclk), .reset_n(reset_n), .line_start(line_start),
    .line_num(line_num), .field_odd(field_odd), .active_start(active_start),
    .pix_valid(pix_valid), .pix_level(pix_level), .pix_ready(pix_ready), .wr_en(wr_en),
    .wr_addr(wr_addr), .wr_data(wr_data), .vid_valid(vid_valid), .vid_sample(vid_sample),
    .vid_ready(vid_ready), .caption_byte_pair(caption_byte_pair),
    .extended_caption_byte_pair(extended_caption_byte_pair), .cc_busy(cc_busy));
  cci_sink u_cci_sink (.mclk(mclk), .reset_n(reset_n), .vid_valid(vid_valid),
    .vid_sample(vid_sample), .vid_ready(vid_ready), .mode(sink_mode));

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("checks=%0d mismatches=%0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  task automatic wr(input logic [4:0] a, input logic [7:0] d);
    @(posedge mclk);
    wr_en <= 1'b1;
    wr_addr <= a;
    wr_data <= d;
    @(posedge mclk);
    wr_en <= 1'b0;
  endtask

  // offers exactly n pixels; the last one is dropped at the edge that takes it
  task automatic push(input int n, input logic [9:0] lvl);
    int tgt;
    tgt = n_acc + n;
    @(posedge mclk);
    pix_valid <= 1'b1;
    pix_level <= lvl;
    do begin
      @(negedge mclk);
    end while (n_acc + int'(pix_ready) < tgt);
    @(posedge mclk);
    pix_valid <= 1'b0;
  endtask

  task automatic line(input logic [9:0] num, input logic odd, input int n);
    int k;
    @(posedge mclk);
    line_start <= 1'b1;
    line_num <= num;
    field_odd <= odd;
    @(posedge mclk);
    line_start <= 1'b0;
    active_start <= 1'b1;
    @(posedge mclk);
    active_start <= 1'b0;
    base = u_cci_sink.got_q.size();
    push(n, 10'h3ff);
    // judged at the falling edge, clear of the sink's and counter's updates
    k = 0;
    do begin
      @(negedge mclk);
      k++;
    end while (u_cci_sink.got_q.size() != n_acc && k < 500);
    chk(16'(u_cci_sink.got_q.size()), 16'(n_acc));
  endtask

  // run-in judged by its extremes per bit, later bits by their middle sample
  task automatic cap_check(input logic [15:0] pair);
    logic [9:0] hi;
    logic [9:0] lo;
    for (int b = 0; b < 27; b++) begin
      hi = 10'h000;
      lo = 10'h3ff;
      for (int i = 0; i < BIT_N; i++) begin
        s = u_cci_sink.got_q[base + b * BIT_N + i];
        hi = (s.level > hi) ? s.level : hi;
        lo = (s.level < lo) ? s.level : lo;
      end
      s = u_cci_sink.got_q[base + b * BIT_N + BIT_N / 2];
      chk(16'(s.caption), 16'h0001);
      if (b < 7) begin
        chk(16'(hi), 16'(CCI_LVL_HIGH));
        chk(16'(lo), 16'(CCI_LVL_BLANK));
      end else if (b < 9 || b == 26) begin
        chk(16'(s.level), 16'(CCI_LVL_BLANK));
      end else if (b == 9) begin
        chk(16'(s.level), 16'(CCI_LVL_HIGH));
      end else begin
        chk(16'(s.level), 16'(pair[b - 10] ? CCI_LVL_HIGH : CCI_LVL_BLANK));
      end
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (16) @(posedge mclk);
    reset_n <= 1'b1;
    @(negedge mclk);
    chk(caption_byte_pair, {CCI_BYTE_RST, CCI_BYTE_RST});
    chk(extended_caption_byte_pair, {CCI_BYTE_RST, CCI_BYTE_RST});
    chk(16'({vid_valid, cc_busy}), 16'h0000);
    wr(CCI_ADDR_CAP_LO, 8'h55);
    wr(CCI_ADDR_CAP_HI, 8'hc3);
    wr(CCI_ADDR_EXT_LO, 8'ha5);
    wr(CCI_ADDR_EXT_HI, 8'h3c);
    wr(5'h0c, 8'hff);
    wr(5'h07, 8'hff);
    @(negedge mclk);
    chk(caption_byte_pair, 16'hc355);
    chk(extended_caption_byte_pair, 16'h3ca5);
    line(10'h014, 1'b1, 4);
    s = u_cci_sink.got_q[base + 3];
    chk(16'(s), 16'h03ff);
    // full buffer must refuse, then drain with nothing lost
    sink_mode <= 2'h2;
    push(2, 10'h077);
    @(posedge mclk);
    pix_valid <= 1'b1;
    repeat (8) @(posedge mclk);
    @(negedge mclk);
    chk(16'(pix_ready), 16'h0000);
    @(posedge mclk);
    pix_valid <= 1'b0;
    sink_mode <= 2'h0;
    repeat (20) @(posedge mclk);
    chk(16'(u_cci_sink.got_q.size()), 16'(n_acc));
    s = u_cci_sink.got_q[u_cci_sink.got_q.size() - 1];
    chk(16'(s), 16'h0077);
    sink_mode <= 2'h1;
    line(CCI_ODD_LINE, 1'b1, 27 * BIT_N);
    cap_check(16'hc355);
    chk(16'(busy_seen), 16'h0001);
    chk(16'(cc_busy), 16'h0000);
    sink_mode <= 2'h0;
    line(CCI_EVEN_LINE, 1'b0, 27 * BIT_N);
    cap_check(16'h3ca5);
    line(CCI_QUIET_LINE, 1'b0, 8);
    s = u_cci_sink.got_q[base + 4];
    chk(16'(s), 16'({1'b1, CCI_LVL_BLANK}));
    // line 21 of an even field is blanked but carries no caption
    line(CCI_ODD_LINE, 1'b0, 8);
    s = u_cci_sink.got_q[base + 4];
    chk(16'(s), 16'({1'b1, CCI_LVL_BLANK}));
    chk(16'(cc_busy), 16'h0000);
    chk(16'(u_cci_sink.got_q.size()), 16'(n_acc));
    complete_run();
  end

  initial begin
    #2000000;
    n_mismatch++;
    complete_run();
  end
endmodule

// >>> bench/cci_sink.sv
// sink model of the composite video path with selectable stall patterns
`timescale 1ns/1ps
module cci_sink (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic vid_valid,
  input cci_pkg::cci_smp_t vid_sample,
  output logic vid_ready,
  input wire logic [1:0] mode
);
  import cci_pkg::*;
  cci_smp_t got_q[$];
  logic tog_r;
  // mode 0 takes every sample, 1 every other cycle, 2 refuses all
  always @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      tog_r <= 1'b0;
      vid_ready <= 1'b0;
    end else begin
      tog_r <= ~tog_r;
      vid_ready <= (mode == 2'h0) || (mode == 2'h1 && tog_r);
    end
  end
  always @(posedge mclk) begin
    if (reset_n && vid_valid && vid_ready) begin
      got_q.push_back(vid_sample);
    end
  end
endmodule

// >>> rtl/cci_buf2.sv
// two-entry skid buffer with registered outputs on both sides
`timescale 1ns/1ps
module cci_buf2 #(
  parameter int W = 11
) (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic in_valid,
  input wire logic [W-1:0] in_data,
  output logic in_ready,
  output logic out_valid,
  output logic [W-1:0] out_data,
  input wire logic out_ready
);
  logic skid_v_r;
  logic [W-1:0] skid_r;
  // mirrors an empty skid slot so the ready output leaves a flop directly
  logic in_rdy_r;
  logic out_v_r;
  logic [W-1:0] out_r;

  // ----------------------------------------------------------------
  // steering
  // ----------------------------------------------------------------
  wire drain = out_ready || !out_v_r;
  wire take = in_valid && !skid_v_r;

  // second slot catches the word that arrives while the head is stalled
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      skid_v_r <= 1'b0;
      skid_r <= '0;
      in_rdy_r <= 1'b1;
      out_v_r <= 1'b0;
      out_r <= '0;
    end else if (drain) begin
      out_v_r <= skid_v_r || in_valid;
      out_r <= skid_v_r ? skid_r : in_data;
      skid_v_r <= 1'b0;
      in_rdy_r <= 1'b1;
    end else if (take) begin
      skid_v_r <= 1'b1;
      skid_r <= in_data;
      in_rdy_r <= 1'b0;
    end
  end

  assign in_ready = in_rdy_r;
  assign out_valid = out_v_r;
  assign out_data = out_r;

  a_no_loss_stall: assert property (@(posedge mclk) disable iff (!reset_n)
    out_v_r && !out_ready |=> out_v_r && $stable(out_r))
    else $error("head word changed while stalled");
endmodule

// >>> rtl/cci_inserter.sv
// caption line inserter: replaces pixels on caption lines with the caption waveform
`timescale 1ns/1ps
// Contract
// - On line 21 of odd fields the caption waveform is placed in the active part of the line.
// - Each caption line opens with seven sine cycles locked to the caption bit timing.
// - After the run-in the output sits at blanking for two bits, then sends a start bit of one.
// - Sixteen data bits follow the start bit, taken from the two caption data bytes.
// - Even fields carry extended captions on line 284 from the two extended data bytes.
// - Pixel input on lines 21 and 282 is ignored and replaced by the caption waveform, or by blanking where no caption is sent.
// - Run-in and bit timing is counted in accepted pixel samples, so the pix_valid handshake paces it.
// - The caption byte pair lives in two host-written bytes at subaddresses 0A and 0B.
// - The extended byte pair lives in two host-written bytes at subaddresses 08 and 09.
module cci_inserter (
  input wire logic mclk,
  input wire logic reset_n,
  input wire logic line_start,
  input wire logic [9:0] line_num,
  input wire logic field_odd,
  input wire logic active_start,
  input wire logic pix_valid,
  input wire logic [9:0] pix_level,
  output logic pix_ready,
  input wire logic wr_en,
  input wire logic [4:0] wr_addr,
  input wire logic [7:0] wr_data,
  output logic vid_valid,
  output cci_pkg::cci_smp_t vid_sample,
  input wire logic vid_ready,
  output logic [15:0] caption_byte_pair,
  output logic [15:0] extended_caption_byte_pair,
  output logic cc_busy
);
  import cci_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [9:0] sine_lvl(input logic [3:0] idx);
    logic [9:0] v;
    v = 10'h168;
    case (idx)
      4'h0: v = 10'h168;
      4'h1: v = 10'h196;
      4'h2: v = 10'h1bd;
      4'h3: v = 10'h1d7;
      4'h4: v = 10'h1e0;
      4'h5: v = 10'h1d7;
      4'h6: v = 10'h1bd;
      4'h7: v = 10'h196;
      4'h8: v = 10'h168;
      4'h9: v = 10'h13a;
      4'ha: v = 10'h113;
      4'hb: v = 10'h0f9;
      4'hc: v = 10'h0f0;
      4'hd: v = 10'h0f9;
      4'he: v = 10'h113;
      default: v = 10'h13a;
    endcase
    return v;
  endfunction

  function automatic logic wr_hit(input logic en, input logic [4:0] a,
                                  input logic [4:0] want);
    return en && (a == want);
  endfunction

  // ----------------------------------------------------------------
  // host byte registers
  // ----------------------------------------------------------------
  logic [7:0] cap_lo_r;
  logic [7:0] cap_hi_r;
  logic [7:0] ext_lo_r;
  logic [7:0] ext_hi_r;

  wire hit_cap_lo = wr_hit(wr_en, wr_addr, CCI_ADDR_CAP_LO);
  wire hit_cap_hi = wr_hit(wr_en, wr_addr, CCI_ADDR_CAP_HI);
  wire hit_ext_lo = wr_hit(wr_en, wr_addr, CCI_ADDR_EXT_LO);
  wire hit_ext_hi = wr_hit(wr_en, wr_addr, CCI_ADDR_EXT_HI);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cap_lo_r <= CCI_BYTE_RST;
      cap_hi_r <= CCI_BYTE_RST;
      ext_lo_r <= CCI_BYTE_RST;
      ext_hi_r <= CCI_BYTE_RST;
    end else begin
      if (hit_cap_lo) cap_lo_r <= wr_data;
      if (hit_cap_hi) cap_hi_r <= wr_data;
      if (hit_ext_lo) ext_lo_r <= wr_data;
      if (hit_ext_hi) ext_hi_r <= wr_data;
    end
  end

  // ----------------------------------------------------------------
  // line classification, sampled at line start
  // ----------------------------------------------------------------
  logic cap_line_r;
  logic quiet_line_r;
  logic even_line_r;

  wire odd_cap = field_odd && (line_num == CCI_ODD_LINE);
  wire even_cap = !field_odd && (line_num == CCI_EVEN_LINE);
  wire quiet = (line_num == CCI_ODD_LINE) || (line_num == CCI_QUIET_LINE);

  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      cap_line_r <= 1'b0;
      quiet_line_r <= 1'b0;
      even_line_r <= 1'b0;
    end else if (line_start) begin
      cap_line_r <= odd_cap || even_cap;
      quiet_line_r <= quiet || odd_cap || even_cap;
      even_line_r <= even_cap;
    end
  end

  // ----------------------------------------------------------------
  // waveform sequencer, paced by accepted sample slots
  // ----------------------------------------------------------------
  cci_state_t st_r;
  cci_state_t st_nxt;
  logic [3:0] seg_cnt_r;
  logic [3:0] sin_idx_r;
  logic [4:0] bit_idx_r;
  logic [15:0] shift_r;

  logic buf_in_ready;
  wire fire = pix_valid && buf_in_ready;
  wire seg_end = fire && (seg_cnt_r == CCI_SEG_CYC - 4'h1);
  wire bit_end = seg_end && (sin_idx_r == CCI_SEG_LAST);
  wire launch = (st_r == CCI_WAIT) && active_start;
  // lower subaddress byte sits in the low half so it leaves first
  wire [15:0] load_pair = even_line_r ? {ext_hi_r, ext_lo_r} : {cap_hi_r, cap_lo_r};
  wire [4:0] bit_last = (st_r == CCI_RUNIN) ? CCI_RUNIN_BITS - 5'h01 :
                        (st_r == CCI_HOLD) ? CCI_HOLD_BITS - 5'h01 :
                        (st_r == CCI_DATA) ? CCI_DATA_BITS - 5'h01 : 5'h00;
  wire phase_done = bit_end && (bit_idx_r == bit_last);

  always_comb begin
    st_nxt = st_r;
    case (st_r)
      CCI_WAIT: begin
        if (launch) st_nxt = CCI_RUNIN;
      end
      CCI_RUNIN: begin
        if (phase_done) st_nxt = CCI_HOLD;
      end
      CCI_HOLD: begin
        if (phase_done) st_nxt = CCI_START;
      end
      CCI_START: begin
        if (phase_done) st_nxt = CCI_DATA;
      end
      CCI_DATA: begin
        if (phase_done) st_nxt = CCI_TAIL;
      end
      default: st_nxt = st_r;
    endcase
    if (line_start) st_nxt = (odd_cap || even_cap) ? CCI_WAIT : CCI_IDLE;
  end

  // counters restart at each phase so the sine stays locked to bit edges
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) begin
      st_r <= CCI_IDLE;
      seg_cnt_r <= 4'h0;
      sin_idx_r <= 4'h0;
      bit_idx_r <= 5'h00;
      shift_r <= 16'h0000;
    end else begin
      st_r <= st_nxt;
      if (launch || line_start) begin
        seg_cnt_r <= 4'h0;
        sin_idx_r <= 4'h0;
        bit_idx_r <= 5'h00;
        if (launch) shift_r <= load_pair;
      end else if (fire) begin
        seg_cnt_r <= seg_end ? 4'h0 : seg_cnt_r + 4'h1;
        if (seg_end) sin_idx_r <= sin_idx_r + 4'h1;
        if (bit_end) bit_idx_r <= phase_done ? 5'h00 : bit_idx_r + 5'h01;
        if (bit_end && st_r == CCI_DATA) shift_r <= {1'b0, shift_r[15:1]};
      end
    end
  end

  // ----------------------------------------------------------------
  // sample selection
  // ----------------------------------------------------------------
  wire [9:0] gen_lvl = (st_r == CCI_RUNIN) ? sine_lvl(sin_idx_r) :
                       (st_r == CCI_START) ? CCI_LVL_HIGH :
                       (st_r == CCI_DATA && shift_r[0]) ? CCI_LVL_HIGH :
                       CCI_LVL_BLANK;
  // pixels on quiet lines are still taken so the source never stalls on them
  cci_smp_t buf_in;
  assign buf_in = {quiet_line_r, quiet_line_r ? gen_lvl : pix_level};

  cci_buf2 #(.W($bits(cci_smp_t))) u_buf (
    .mclk(mclk),
    .reset_n(reset_n),
    .in_valid(pix_valid),
    .in_data(buf_in),
    .in_ready(buf_in_ready),
    .out_valid(vid_valid),
    .out_data(vid_sample),
    .out_ready(vid_ready)
  );

  logic busy_r;
  always_ff @(posedge mclk or negedge reset_n) begin
    if (!reset_n) busy_r <= 1'b0;
    else busy_r <= (st_nxt != CCI_IDLE) && (st_nxt != CCI_TAIL);
  end

  assign pix_ready = buf_in_ready;
  assign cc_busy = busy_r;
  assign caption_byte_pair = {cap_hi_r, cap_lo_r};
  assign extended_caption_byte_pair = {ext_hi_r, ext_lo_r};

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!reset_n);

  a_caption_line_gate: assert property (
    st_r == CCI_WAIT && !line_start |-> cap_line_r)
    else $error("waveform armed on a non-caption line");
  a_runin_seven_bits: assert property (
    st_r == CCI_RUNIN && phase_done && !line_start |-> bit_idx_r == 5'h06 ##1 st_r == CCI_HOLD)
    else $error("run-in not seven cycles");
  a_hold_then_start: assert property (
    st_r == CCI_HOLD && fire && !line_start |-> buf_in.level == CCI_LVL_BLANK ##0
    (phase_done ? bit_idx_r == 5'h01 : 1'b1))
    else $error("hold phase wrong");
  a_start_bit_high: assert property (
    st_r == CCI_START && !line_start |-> buf_in.caption && buf_in.level == CCI_LVL_HIGH)
    else $error("start bit not one");
  a_data_sixteen: assert property (
    st_r == CCI_DATA && phase_done && !line_start |-> bit_idx_r == 5'h0f ##1 st_r == CCI_TAIL)
    else $error("data not sixteen bits");
  a_ext_source: assert property (
    launch && even_line_r && !line_start |=> shift_r == $past(extended_caption_byte_pair))
    else $error("extended bytes not loaded");
  a_pixels_ignored: assert property (
    quiet_line_r |-> buf_in.caption && buf_in.level == gen_lvl &&
    (st_r != CCI_IDLE || buf_in.level == CCI_LVL_BLANK))
    else $error("pixel leaked onto caption line");
  a_cap_reg_write: assert property (
    hit_cap_hi |=> caption_byte_pair[15:8] == $past(wr_data))
    else $error("caption byte write lost");
  a_ext_reg_write: assert property (
    hit_ext_lo |=> extended_caption_byte_pair[7:0] == $past(wr_data))
    else $error("extended byte write lost");
  a_lsb_first: assert property (
    st_r == CCI_DATA && bit_end && !phase_done && !line_start |=>
    shift_r == {1'b0, $past(shift_r[15:1])})
    else $error("data not sent lsb first");
endmodule

// >>> rtl/cci_pkg.sv
// package: constants and types for the caption line inserter
package cci_pkg;

  // ----------------------------------------------------------------
  // host subaddresses and reset values
  // ----------------------------------------------------------------
  localparam logic [4:0] CCI_ADDR_EXT_LO = 5'h08;
  localparam logic [4:0] CCI_ADDR_EXT_HI = 5'h09;
  localparam logic [4:0] CCI_ADDR_CAP_LO = 5'h0a;
  localparam logic [4:0] CCI_ADDR_CAP_HI = 5'h0b;
  localparam logic [7:0] CCI_BYTE_RST = 8'h00;

  // ----------------------------------------------------------------
  // line numbers
  // ----------------------------------------------------------------
  localparam logic [9:0] CCI_ODD_LINE = 10'h015;
  localparam logic [9:0] CCI_EVEN_LINE = 10'h11c;
  localparam logic [9:0] CCI_QUIET_LINE = 10'h11a;

  // ----------------------------------------------------------------
  // waveform levels and layout
  // ----------------------------------------------------------------
  localparam logic [9:0] CCI_LVL_BLANK = 10'h0f0;
  localparam logic [9:0] CCI_LVL_HIGH = 10'h1e0;
  localparam logic [4:0] CCI_RUNIN_BITS = 5'h07;
  localparam logic [4:0] CCI_HOLD_BITS = 5'h02;
  localparam logic [4:0] CCI_DATA_BITS = 5'h10;
  localparam logic [3:0] CCI_SEG_LAST = 4'hf;

  // ----------------------------------------------------------------
  // timing: one bit period is sixteen sine segments
  // ----------------------------------------------------------------
  localparam int CCI_CLK_MHZ = 25;
  localparam int CCI_BIT_NS = 1986;
  localparam int CCI_SEG_CYC_I = (CCI_BIT_NS * CCI_CLK_MHZ) / (16 * 1000);
  localparam logic [3:0] CCI_SEG_CYC = 4'(CCI_SEG_CYC_I < 1 ? 1 : CCI_SEG_CYC_I);

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    CCI_IDLE, CCI_WAIT, CCI_RUNIN, CCI_HOLD, CCI_START, CCI_DATA, CCI_TAIL
  } cci_state_t;

  typedef struct packed {
    logic caption;
    logic [9:0] level;
  } cci_smp_t;

endpackage
